// ===== hw/tzs_pkg.sv
// Constants and encodings of the transmit timeslot zero-suppression control.
// Assumes one clock domain and a byte-wide register port.
// Behaviour
// - 24 timeslot control registers at consecutive addresses from base, slot n at base+n.
// - Select field 00/01/11 routes D/E data from LAPD transmitter 1/2/3.
// - Select 10 takes D/E source from data-link field of signaling select register.
// - Suppression type 00 passes octet; 01 stuffs bit 7.
// - Type 10 in non-signaling frame stuffs bit 8.
// - Type 10 in signaling frame stuffs bit 7 only when signaling bit is zero.
// - Type 11 replaces octet with fixed code 0x98.
// - Read-only 8-bit revision register; value may change between revisions.
package tzs_pkg;
	localparam logic [15:0] TSC_BASE      = 16'h0300;
	localparam logic [15:0] TSC_LAST      = 16'h0317;
	localparam logic [15:0] SIG_DL_SEL    = 16'h010A;
	localparam logic [15:0] REV_ID_ADDR   = 16'h01FF;
	localparam int          NUM_SLOTS     = 24;
	localparam int          SEL_MSB       = 7;
	localparam int          SEL_LSB       = 6;
	localparam int          ZS_MSB        = 5;
	localparam int          ZS_LSB        = 4;
	localparam int          DE_MSB        = 3;
	localparam int          DE_LSB        = 2;
	localparam logic [7:0]  TSC_RESET     = 8'h80;
	localparam logic [7:0]  SIG_DL_RESET  = 8'h00;
	localparam logic [7:0]  REV_ID_VALUE  = 8'h5A; // Arbitrary value
	localparam logic [7:0]  DDS_CODE      = 8'h98;
	localparam logic [7:0]  BIT7_MASK     = 8'h02;
	localparam logic [7:0]  BIT8_MASK     = 8'h01;
	typedef enum logic [1:0] {
		TZS_LAPD1 = 2'b00,
		TZS_LAPD2 = 2'b01,
		TZS_DLINK = 2'b10,
		TZS_LAPD3 = 2'b11
	} tzs_sel_e;
	typedef enum logic [1:0] {
		TZS_ZS_NONE = 2'b00,
		TZS_ZS_B7   = 2'b01,
		TZS_ZS_SIG  = 2'b10,
		TZS_ZS_DDS  = 2'b11
	} tzs_zs_e;
endpackage

// ===== hw/tzs_ctrl.sv
// Per-timeslot transmit source select and zero-code suppression.
// Assumes a synchronous register port and a slot stream with valid/ready handshakes.
//
// Implementation choice: the strobed register port.
module tzs_ctrl (
	input  wire logic        mclk,         // 250 MHz clock
	input  wire logic        rstn,         // Async reset, active low
	input  wire logic [15:0] reg_addr,     // Register address
	input  wire logic [7:0]  reg_wdata,    // Write data
	input  wire logic        reg_wr,       // Write strobe
	input  wire logic        reg_rd,       // Read strobe
	output logic      [7:0]  reg_rdata,    // Read data, cycle after strobe
	input  wire logic        in_valid,     // Slot octet present
	output logic             in_ready,     // Buffer can take octet
	input  wire logic [4:0]  in_slot,      // Timeslot number
	input  wire logic [7:0]  in_octet,     // Payload octet, bit 8 in lsb
	input  wire logic        in_sig_frame, // Frame carries signaling
	input  wire logic        in_sig_bit,   // Signaling bit carried
	input  wire logic [7:0]  lapd1_octet,  // D/E data, LAPD transmitter 1
	input  wire logic [7:0]  lapd2_octet,  // D/E data, LAPD transmitter 2
	input  wire logic [7:0]  lapd3_octet,  // D/E data, LAPD transmitter 3
	input  wire logic [7:0]  dlink_octet,  // D/E data, data-link sources
	output logic             out_valid,    // Output octet present
	input  wire logic        out_ready,    // Line side takes octet
	output logic      [4:0]  out_slot,     // Timeslot of output
	output logic      [7:0]  out_octet,    // Transmitted octet
	output logic      [1:0]  out_de_src    // Data-link source for select 10
);
	logic [7:0] tsc_r [tzs_pkg::NUM_SLOTS];
	logic [7:0] sig_dl_r;
	logic       rst_s1_r;
	logic       rst_s2_r;
	logic       rst_n;
	logic [4:0] addr_idx;
	logic       hit_tsc;
	logic [7:0] cur_ctl;
	logic [7:0] src_oct;
	logic [7:0] proc_nxt;
	logic [4:0] buf_slot  [2];
	logic [7:0] buf_oct   [2];
	logic       buf_ptr_w_r;
	logic       buf_ptr_r_r;
	logic [1:0] buf_cnt_r;
	logic       push;
	logic       pop;
	logic [4:0] slot_nxt;

	// Reset release synchroniser
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rst_n = rst_s2_r;

	// Address decode of the timeslot array
	assign addr_idx = reg_addr[4:0];
	assign hit_tsc  = (reg_addr >= tzs_pkg::TSC_BASE) && (reg_addr <= tzs_pkg::TSC_LAST);

	// Timeslot control register writes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < tzs_pkg::NUM_SLOTS; i++) begin
				tsc_r[i] <= tzs_pkg::TSC_RESET;
			end
		end else if (reg_wr && hit_tsc) begin
			tsc_r[addr_idx] <= reg_wdata;
		end
	end

	// Signaling and data-link select register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sig_dl_r <= tzs_pkg::SIG_DL_RESET;
		end else if (reg_wr && reg_addr == tzs_pkg::SIG_DL_SEL) begin
			sig_dl_r <= reg_wdata;
		end
	end

	// Register reads, unmapped reads return zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (hit_tsc) begin
				reg_rdata <= tsc_r[addr_idx];
			end else if (reg_addr == tzs_pkg::SIG_DL_SEL) begin
				reg_rdata <= sig_dl_r;
			end else if (reg_addr == tzs_pkg::REV_ID_ADDR) begin
				reg_rdata <= tzs_pkg::REV_ID_VALUE;
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Source selection and suppression of the selected source octet
	always_comb begin
		cur_ctl = (in_slot < 5'(tzs_pkg::NUM_SLOTS)) ? tsc_r[in_slot] : tzs_pkg::TSC_RESET;
		src_oct = in_octet;
		unique case (tzs_pkg::tzs_sel_e'(cur_ctl[tzs_pkg::SEL_MSB:tzs_pkg::SEL_LSB]))
			tzs_pkg::TZS_LAPD1: src_oct = lapd1_octet;
			tzs_pkg::TZS_LAPD2: src_oct = lapd2_octet;
			tzs_pkg::TZS_LAPD3: src_oct = lapd3_octet;
			tzs_pkg::TZS_DLINK: src_oct = dlink_octet;
		endcase
		proc_nxt = src_oct;
		if (src_oct == 8'h00) begin
			unique case (tzs_pkg::tzs_zs_e'(cur_ctl[tzs_pkg::ZS_MSB:tzs_pkg::ZS_LSB]))
				tzs_pkg::TZS_ZS_NONE: proc_nxt = src_oct;
				tzs_pkg::TZS_ZS_B7:   proc_nxt = src_oct | tzs_pkg::BIT7_MASK;
				tzs_pkg::TZS_ZS_SIG: begin
					if (!in_sig_frame) begin
						proc_nxt = src_oct | tzs_pkg::BIT8_MASK;
					end else if (!in_sig_bit) begin
						proc_nxt = src_oct | tzs_pkg::BIT7_MASK;
					end else begin
						proc_nxt = src_oct;
					end
				end
				tzs_pkg::TZS_ZS_DDS:  proc_nxt = tzs_pkg::DDS_CODE;
			endcase
		end
		slot_nxt = in_slot;
	end

	// Two-entry output buffer handshakes
	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (push) begin
			buf_slot[buf_ptr_w_r] <= slot_nxt;
			buf_oct[buf_ptr_w_r]  <= proc_nxt;
		end
	end

	// Buffer pointers and occupancy
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			buf_ptr_w_r <= 1'b0;
			buf_ptr_r_r <= 1'b0;
			buf_cnt_r   <= 2'd0;
		end else begin
			if (push) begin
				buf_ptr_w_r <= ~buf_ptr_w_r;
			end
			if (pop) begin
				buf_ptr_r_r <= ~buf_ptr_r_r;
			end
			buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// Registered outputs of the buffer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			in_ready   <= 1'b0;
			out_valid  <= 1'b0;
			out_slot   <= 5'd0;
			out_octet  <= 8'h00;
			out_de_src <= 2'b00;
		end else begin
			in_ready   <= (buf_cnt_r + {1'b0, push} - {1'b0, pop}) < 2'd2;
			out_valid  <= (buf_cnt_r + {1'b0, push} - {1'b0, pop}) != 2'd0;
			out_de_src <= sig_dl_r[tzs_pkg::DE_MSB:tzs_pkg::DE_LSB];
			if (pop) begin
				out_slot  <= (buf_cnt_r == 2'd1 && push) ? slot_nxt : buf_slot[~buf_ptr_r_r];
				out_octet <= (buf_cnt_r == 2'd1 && push) ? proc_nxt : buf_oct[~buf_ptr_r_r];
			end else if (buf_cnt_r == 2'd0 && push) begin
				out_slot  <= slot_nxt;
				out_octet <= proc_nxt;
			end
		end
	end
endmodule

// ===== dv/tzs_sink.sv
// Line-side sink model: takes octets with random stalls.
// Assumes the valid/ready output handshake of tzs_ctrl.
module tzs_sink (
	input  wire logic mclk,     // Clock
	input  wire logic stall,    // Heavy stall mode
	output logic      out_ready // Takes octet
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 32'h4230;
	// Ready one cycle in two, or one in eight when stalling
	always @(posedge mclk) begin
		out_ready <= ($random(seed) & (stall ? 7 : 1)) == 0;
	end
endmodule

// ===== dv/tzs_ctrl_chk.sv
// Checker of register port and slot stream timing.
// Bound to tzs_ctrl; sees only its ports.
module tzs_ctrl_chk (
	input wire logic        mclk,      // Clock
	input wire logic        rstn,      // Async reset, active low
	input wire logic        reg_wr,    // Write strobe
	input wire logic        reg_rd,    // Read strobe
	input wire logic        in_valid,  // Slot octet offered
	input wire logic        in_ready,  // Buffer has room
	input wire logic        out_valid, // Output octet present
	input wire logic        out_ready, // Line side takes octet
	input wire logic [15:0] reg_addr,  // Register address
	input wire logic [7:0]  reg_wdata, // Write data
	input wire logic [7:0]  reg_rdata, // Read data
	input wire logic [7:0]  out_octet, // Transmitted octet
	input wire logic [4:0]  out_slot,  // Timeslot of output
	input wire logic [1:0]  out_de_src // Data-link source
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Register port
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
	unmap_rd_a: assert property (reg_rd && reg_addr == 16'h0318 |=> reg_rdata == 8'h00) else $error("unmapped");
	de_src_a: assert property (reg_wr && reg_addr == tzs_pkg::SIG_DL_SEL |-> ##2
		out_de_src == $past(reg_wdata[tzs_pkg::DE_MSB:tzs_pkg::DE_LSB], 2)) else $error("de source");
	// Slot stream
	hold_out_a: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_octet) && $stable(out_slot)) else $error("output moved");
	answer_a: assert property (in_valid && in_ready && !out_valid |=> out_valid) else $error("no answer");
	cause_a: assert property ($rose(out_valid) |-> $past(in_valid) && $past(in_ready)) else $error("no cause");
	slot_rng_a: assert property (out_valid |-> out_slot < 5'd24) else $error("slot range");
	full_stop_a: assert property ((out_valid && !out_ready && in_valid) [*4] |-> !in_ready) else $error("full");
	cover property (out_valid && !out_ready);
	cover property (in_valid && !in_ready);
	cover property (reg_wr && reg_addr == tzs_pkg::SIG_DL_SEL);
endmodule

// ===== dv/tzs_ctrl_tb.sv
// Bench of tzs_ctrl: register map, source routing, zero suppression.
// Assumes the tzs_sink model and the tzs_ctrl_chk checker.
module tzs_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, in_valid = 0, sf = 0, sb = 0, stall = 0;
	logic       in_ready, out_valid, out_ready;
	logic [15:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata, oct = 0, l1 = 0, l2 = 0, l3 = 0, dl = 0, out_octet;
	logic [4:0] slot = 0, out_slot;
	logic [1:0] out_de_src;
	logic [7:0] ctl [24];
	logic [12:0] q [$];
	int         seed = 32'h4230, fail_count = 0, n_tests = 0;
	initial forever #2 mclk = !mclk;
	tzs_ctrl tzs_ctrl_inst (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid,
		.in_ready, .in_slot(slot), .in_octet(oct), .in_sig_frame(sf), .in_sig_bit(sb), .lapd1_octet(l1),
		.lapd2_octet(l2), .lapd3_octet(l3), .dlink_octet(dl), .out_valid, .out_ready, .out_slot, .out_octet,
		.out_de_src);
	tzs_sink tzs_sink_inst (.mclk, .stall, .out_ready);
	// Compare and count
	task automatic chk(input logic [15:0] s, e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Register bus cycles
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 0;
		@(posedge mclk);
		chk(reg_rdata, e);
	endtask
	// Expected octet for a slot control value
	function automatic logic [7:0] ex(input logic [7:0] c);
		logic [7:0] s;
		s = c[7:6] == 0 ? l1 : c[7:6] == 1 ? l2 : c[7:6] == 3 ? l3 : dl;
		if (s != 0) return s;
		case (c[5:4])
			0: return 8'h00;
			1: return 8'h02;
			2: return sf ? (sb ? 8'h00 : 8'h02) : 8'h01;
			default: return 8'h98;
		endcase
	endfunction
	task automatic final_report;
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Line-side scoreboard
	always @(posedge mclk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) chk({3'b0, out_slot, out_octet}, {3'b0, q.pop_front()});
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		final_report;
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1;
		repeat (3) @(posedge mclk);
		rd(16'h0300, 8'h80);
		rd(16'h0317, 8'h80);
		wr(16'h0318, 8'h55);
		rd(16'h0318, 8'h00);
		wr(tzs_pkg::REV_ID_ADDR, 8'hFF);
		rd(tzs_pkg::REV_ID_ADDR, tzs_pkg::REV_ID_VALUE);
		$display("test reset done");
		for (int n = 0; n < 24; n++) begin
			ctl[n] = {n[1:0], n[3:2], 4'($random(seed))};
			wr(16'h0300 + 16'(n), ctl[n]);
		end
		for (int n = 0; n < 24; n++) rd(16'h0300 + 16'(n), ctl[n]);
		wr(tzs_pkg::SIG_DL_SEL, 8'h0C);
		@(posedge mclk);
		chk({14'h0000, out_de_src}, 16'h0003);
		$display("test map done");
		for (int i = 0; i < 300; i++) begin
			stall <= i[5];
			slot <= 5'($unsigned($random(seed)) % 24);
			{sf, sb} <= 2'($random(seed));
			oct <= 8'($random(seed));
			{l1, l2, l3, dl} <= $random(seed) & {32{i[0]}};
			in_valid <= 1;
			@(posedge mclk);
			while (in_ready !== 1'b1) @(posedge mclk);
			q.push_back({slot, ex(ctl[slot])});
		end
		in_valid <= 0;
		stall <= 0;
		repeat (40) @(posedge mclk);
		chk(16'(q.size()), 16'h0000);
		$display("test stream done");
		final_report;
	end
endmodule
bind tzs_ctrl tzs_ctrl_chk tzs_ctrl_chk_inst (.*);
